//--- gst_pkg.sv
package gst_pkg;

    // Clock-select field encodings.
    localparam logic [1:0] CS_SYS = 2'h1;
    localparam logic [1:0] CS_INST = 2'h0;
    localparam logic [1:0] CS_EXT = 2'h2;

    // System clock select value that runs the shared oscillator.
    localparam logic [1:0] SCS_SOSC = 2'h1;

    // Reset values.
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [1:0] PHASE_RST = 2'h0;

    // Field positions of the count word.
    localparam int HIGH_MSB = 15;
    localparam int HIGH_LSB = 8;
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 0;

    // Instruction clock is the system clock divided by four.
    localparam logic [1:0] INST_PHASE_LAST = 2'h3;

    // Count step and all-ones value.
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

    // Number of pins passed through the input synchroniser.
    localparam int PIN_COUNT = 3;
    localparam int PIN_EXT = 0;
    localparam int PIN_XTAL = 1;
    localparam int PIN_GATE = 2;

    // Selected count source after decoding.
    typedef enum logic [1:0] {
        GST_SRC_SYS,
        GST_SRC_INST,
        GST_SRC_EXT,
        GST_SRC_NONE
    } gst_src_t;

endpackage

//--- gst_presc_if.sv
`timescale 1ns/100ps
`default_nettype none

interface gst_presc_if;
    logic in_tick;
    logic clear;
    logic [1:0] ratio;
    logic out_tick;

    modport feeder (output in_tick, output clear, output ratio, input out_tick);
    modport divider (input in_tick, input clear, input ratio, output out_tick);
endinterface

`default_nettype wire

//--- gst_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module gst_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Each pin passes two flip-flops; only the second stage is read.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- gst_prescale.sv
`timescale 1ns/100ps
`default_nettype none

module gst_prescale (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Tick path.
    gst_presc_if.divider pre
);

    logic [2:0] cnt_q;
    logic [2:0] mask;

    // Divide by 1, 2, 4 or 8: pass a tick when the low bits are all ones.
    always_comb begin
        case (pre.ratio)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    assign pre.out_tick = pre.in_tick && !pre.clear && ((cnt_q & mask) == mask);

    // The count is hidden from software and cleared on any count write.
    always_ff @(posedge i_clk) begin
        if (i_rst || pre.clear) begin
            cnt_q <= gst_pkg::PRESC_RST;
        end else if (pre.in_tick) begin
            cnt_q <= 3'((cnt_q + 3'h1) & mask);
        end
    end

    a_presc_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
        pre.clear |=> cnt_q == gst_pkg::PRESC_RST)
        else $error("prescale count not cleared by count write");

    a_presc_div_two: assert property (@(posedge i_clk) disable iff (i_rst)
        (pre.ratio == 2'h1 && pre.in_tick && !pre.clear && pre.out_tick) |=>
        (pre.in_tick && !pre.clear && pre.ratio == 2'h1) |-> !pre.out_tick)
        else $error("divide by two passed two ticks in a row");

endmodule

`default_nettype wire

//--- gst_timer.sv
`timescale 1ns/100ps
`default_nettype none

module gst_timer (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Count byte writes.
    input wire logic i_wr_high,
    input wire logic i_wr_low,
    input wire logic [7:0] i_wdata,
    // Timer control.
    input wire logic i_timer_on,
    input wire logic [1:0] i_clock_select,
    input wire logic i_osc_enable,
    input wire logic [1:0] i_prescale,
    input wire logic i_sync_disable,
    // Gate control.
    input wire logic i_gate_enable,
    input wire logic i_gate_polarity,
    // Shared oscillator control.
    input wire logic i_osc_go,
    input wire logic [1:0] i_sysclk_select,
    input wire logic i_osc_enable_other,
    // Overflow interrupt and power state.
    input wire logic i_ovf_int_enable,
    input wire logic i_ovf_clear,
    input wire logic i_sleep,
    // Pins.
    input wire logic i_ext_clock_pin,
    input wire logic i_crystal_in_pin,
    input wire logic i_gate_pin,
    // Count readback.
    output logic [7:0] o_count_high,
    output logic [7:0] o_count_low,
    // Status.
    output logic o_ovf_flag,
    output logic o_irq,
    output logic o_wake,
    output logic o_osc_run
);

    logic [gst_pkg::PIN_COUNT-1:0] pins_async;
    logic [gst_pkg::PIN_COUNT-1:0] pins_sync;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [1:0] phase_q;
    logic ext_resync_q;
    logic ext_prev_q;
    logic armed_q;
    logic ovf_q;
    logic irq_q;
    logic wake_q;
    logic osc_run_q;
    logic wr_any;
    logic inst_tick;
    logic ext_level;
    logic ext_chosen;
    logic ext_rise;
    logic ext_fall;
    logic gate_open;
    logic run_enable;
    logic src_tick;
    logic cnt_tick;
    logic wrap;
    gst_pkg::gst_src_t src;

    gst_presc_if pre ();

    // Pins pass two flip-flops before any logic reads them.
    assign pins_async[gst_pkg::PIN_EXT] = i_ext_clock_pin;
    assign pins_async[gst_pkg::PIN_XTAL] = i_crystal_in_pin;
    assign pins_async[gst_pkg::PIN_GATE] = i_gate_pin;

    gst_sync2 #(
        .WIDTH(gst_pkg::PIN_COUNT)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    assign wr_any = i_wr_high || i_wr_low;

    // Decode the count source.
    always_comb begin
        case (i_clock_select)
            gst_pkg::CS_SYS: src = gst_pkg::GST_SRC_SYS;
            gst_pkg::CS_INST: src = gst_pkg::GST_SRC_INST;
            gst_pkg::CS_EXT: src = gst_pkg::GST_SRC_EXT;
            default: src = gst_pkg::GST_SRC_NONE;
        endcase
    end

    // The instruction clock ticks once every four system clocks.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_q <= gst_pkg::PHASE_RST;
        end else begin
            phase_q <= 2'(phase_q + 2'h1);
        end
    end

    assign inst_tick = (phase_q == gst_pkg::INST_PHASE_LAST);

    // The oscillator enable of this timer picks the crystal over the pin.
    assign ext_level = i_osc_enable ? pins_sync[gst_pkg::PIN_XTAL]
                                    : pins_sync[gst_pkg::PIN_EXT];

    // Synchronous mode adds a stage aligned to the internal phase clocks.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_resync_q <= 1'b0;
        end else begin
            ext_resync_q <= ext_level;
        end
    end

    // Changing the mode swaps the tap, which may drop or add one edge.
    assign ext_chosen = i_sync_disable ? ext_level : ext_resync_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_chosen;
        end
    end

    assign ext_rise = ext_chosen && !ext_prev_q;
    assign ext_fall = !ext_chosen && ext_prev_q;

    // A falling edge arms counter mode; reset, writes and turning off disarm.
    always_ff @(posedge i_clk) begin
        if (i_rst || wr_any || !i_timer_on) begin
            armed_q <= 1'b0;
        end else if (ext_fall) begin
            armed_q <= 1'b1;
        end
    end

    // Gate passes when its level equals the polarity.
    assign gate_open = (pins_sync[gst_pkg::PIN_GATE] == i_gate_polarity);
    assign run_enable = i_timer_on && (!i_gate_enable || gate_open);

    // Source tick; only asynchronous external counting survives sleep.
    always_comb begin
        case (src)
            gst_pkg::GST_SRC_SYS: src_tick = !i_sleep;
            gst_pkg::GST_SRC_INST: src_tick = inst_tick && !i_sleep;
            gst_pkg::GST_SRC_EXT: src_tick = ext_rise && armed_q
                                             && (i_sync_disable || !i_sleep);
            default: src_tick = 1'b0;
        endcase
    end

    assign pre.in_tick = src_tick && run_enable;
    assign pre.clear = wr_any;
    assign pre.ratio = i_prescale;

    gst_prescale u_presc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .pre(pre)
    );

    assign cnt_tick = pre.out_tick;
    assign wrap = cnt_tick && (count_q == gst_pkg::COUNT_ALL_ONES);

    // Byte writes load the counter directly; otherwise it counts up.
    always_comb begin
        count_d = count_q;
        if (wr_any) begin
            if (i_wr_high) begin
                count_d[gst_pkg::HIGH_MSB:gst_pkg::HIGH_LSB] = i_wdata;
            end
            if (i_wr_low) begin
                count_d[gst_pkg::LOW_MSB:gst_pkg::LOW_LSB] = i_wdata;
            end
        end else if (cnt_tick) begin
            count_d = 16'(count_q + gst_pkg::COUNT_ONE);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= gst_pkg::COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // Sticky overflow; a wrap in the cycle of a clear wins.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ovf_q <= 1'b0;
        end else if (wrap) begin
            ovf_q <= 1'b1;
        end else if (i_ovf_clear) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ovf_q && i_ovf_int_enable;
        end
    end

    // Wake is raised by an enabled overflow while asleep.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= i_sleep && ovf_q && i_ovf_int_enable;
        end
    end

    // The shared oscillator runs on any request and is not stopped by sleep.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_run_q <= 1'b0;
        end else begin
            osc_run_q <= i_osc_enable || i_osc_enable_other || i_osc_go
                         || (i_sysclk_select == gst_pkg::SCS_SOSC);
        end
    end

    assign o_count_high = count_q[gst_pkg::HIGH_MSB:gst_pkg::HIGH_LSB];
    assign o_count_low = count_q[gst_pkg::LOW_MSB:gst_pkg::LOW_LSB];
    assign o_ovf_flag = ovf_q;
    assign o_irq = irq_q;
    assign o_wake = wake_q;
    assign o_osc_run = osc_run_q;

    // Four cycles of full-rate counting with a divide of one.
    sequence s_fosc_run;
        (i_timer_on && !i_gate_enable && i_clock_select == gst_pkg::CS_SYS
         && i_prescale == 2'h0 && !i_sleep && !wr_any)[*4];
    endsequence

    sequence s_counter_unarmed;
        i_timer_on && i_clock_select == gst_pkg::CS_EXT && !armed_q && !wr_any;
    endsequence

    a_fosc_four_per: assert property (@(posedge i_clk) disable iff (i_rst)
        s_fosc_run |=> count_q == 16'($past(count_q, 4) + 16'h0004))
        else $error("full-rate source did not add four in four cycles");

    a_write_high: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr_high |=> o_count_high == $past(i_wdata))
        else $error("high byte write not loaded");

    a_write_low: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr_low |=> o_count_low == $past(i_wdata))
        else $error("low byte write not loaded");

    a_off_holds: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_timer_on && !wr_any) |=> $stable(count_q))
        else $error("count moved while timer off");

    a_gate_holds: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_gate_enable && pins_sync[gst_pkg::PIN_GATE] != i_gate_polarity && !wr_any)
        |=> $stable(count_q))
        else $error("count moved while gate closed");

    a_arm_first: assert property (@(posedge i_clk) disable iff (i_rst)
        s_counter_unarmed |=> $stable(count_q))
        else $error("counted before a falling edge armed counter mode");

    a_inst_quarter: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_on && !i_gate_enable && i_clock_select == gst_pkg::CS_INST
         && i_prescale == 2'h0 && !i_sleep && !wr_any)[*4]
        |=> count_q == 16'($past(count_q, 4) + gst_pkg::COUNT_ONE))
        else $error("instruction clock source did not add one in four cycles");

    a_ovf_sets: assert property (@(posedge i_clk) disable iff (i_rst)
        wrap |=> ovf_q ##1 (o_irq || !$past(i_ovf_int_enable)))
        else $error("wrap did not set the overflow flag or request");

    a_ovf_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
        (ovf_q && !i_ovf_clear) |=> ovf_q)
        else $error("overflow flag dropped without a clear");

    a_osc_runs: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_osc_go || i_osc_enable_other || i_sysclk_select == gst_pkg::SCS_SOSC)
        |=> o_osc_run)
        else $error("shared oscillator not running on request");

    a_sleep_sync_stops: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sleep && !i_sync_disable && !wr_any) |=> $stable(count_q))
        else $error("synchronous count advanced during sleep");

endmodule

`default_nettype wire

//--- gst_ext_src.sv
`timescale 1ns/100ps
`default_nettype none

module gst_ext_src #(
    parameter int HALF = 6
) (
    // Clock.
    input wire logic i_clk,
    // Run request; the pin stands low while it is low.
    input wire logic i_run,
    // Clock pin towards the timer.
    output logic o_pin
);
    int cnt_q = 0;
    logic pin_q = 1'b0;

    assign o_pin = pin_q;

    // A run starts low, so its first edge is a rise before any fall.
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt_q <= 0;
            pin_q <= 1'b0;
        end else if (cnt_q == HALF - 1) begin
            cnt_q <= 0;
            pin_q <= ~pin_q;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wr_h = 1'b0;
    logic wr_l = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic on = 1'b0;
    logic [1:0] cs = 2'h0;
    logic osc_en = 1'b0;
    logic [1:0] presc = 2'h0;
    logic sync_dis = 1'b0;
    logic gate_en = 1'b0;
    logic gate_pol = 1'b0;
    logic gate_pin = 1'b0;
    logic osc_go = 1'b0;
    logic [1:0] scs = 2'h0;
    logic osc_other = 1'b0;
    logic int_en = 1'b0;
    logic ovf_clr = 1'b0;
    logic sleep = 1'b0;
    logic run_e = 1'b0;
    logic run_x = 1'b0;
    logic ext_pin;
    logic xtal_pin;
    logic [7:0] cnt_h;
    logic [7:0] cnt_l;
    logic ovf, irq, wake, osc_run;
    logic [31:0] rnd = 32'hd533;
    logic [19:0] note;
    logic [19:0] exp_q[$];
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    event sample_ev;

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    gst_ext_src ext_u (.i_clk(i_clk), .i_run(run_e), .o_pin(ext_pin));
    gst_ext_src xtal_u (.i_clk(i_clk), .i_run(run_x), .o_pin(xtal_pin));

    gst_timer dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr_high(wr_h), .i_wr_low(wr_l),
        .i_wdata(wdata), .i_timer_on(on), .i_clock_select(cs), .i_osc_enable(osc_en),
        .i_prescale(presc), .i_sync_disable(sync_dis), .i_gate_enable(gate_en),
        .i_gate_polarity(gate_pol), .i_osc_go(osc_go), .i_sysclk_select(scs),
        .i_osc_enable_other(osc_other), .i_ovf_int_enable(int_en), .i_ovf_clear(ovf_clr),
        .i_sleep(sleep), .i_ext_clock_pin(ext_pin), .i_crystal_in_pin(xtal_pin),
        .i_gate_pin(gate_pin), .o_count_high(cnt_h), .o_count_low(cnt_l),
        .o_ovf_flag(ovf), .o_irq(irq), .o_wake(wake), .o_osc_run(osc_run)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wr_byte(input logic hi, input logic [7:0] d);
        @(posedge i_clk);
        wr_h <= hi;
        wr_l <= !hi;
        wdata <= d;
        @(posedge i_clk);
        wr_h <= 1'b0;
        wr_l <= 1'b0;
    endtask

    task automatic run_for(input int m);
        @(posedge i_clk);
        on <= 1'b1;
        tick(m);
        on <= 1'b0;
        tick(4);
    endtask

    // Flags are packed as osc_run, wake, irq, overflow.
    task automatic note_exp(input logic [15:0] c, input logic [3:0] f);
        @(posedge i_clk);
        #1;
        exp_q.push_back({f, c});
        -> sample_ev;
    endtask

    task automatic cmp_count(input logic [15:0] e);
        compares++;
        if ({cnt_h, cnt_l} !== e) begin
            error_cnt++;
            $display("Error t=%0t count got %h exp %h", $time, {cnt_h, cnt_l}, e);
        end
    endtask

    task automatic cmp_flags(input logic [3:0] e);
        compares++;
        if ({osc_run, wake, irq, ovf} !== e) begin
            error_cnt++;
            $display("Error t=%0t flags got %h exp %h", $time, {osc_run, wake, irq, ovf}, e);
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The watcher takes the oldest note whenever a result is sampled.
    initial begin
        forever begin
            @(sample_ev);
            note = exp_q.pop_front();
            cmp_count(note[15:0]);
            cmp_flags(note[19:16]);
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        tick(20);
        i_rst <= 1'b0;
        note_exp(16'h0000, 4'h0);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            wr_byte(1'b1, rnd[15:8]);
            wr_byte(1'b0, rnd[7:0]);
            note_exp(rnd[15:0], 4'h0);
        end
        // Odd full-rate run lengths (67) leave the prescaler part way, so a missed clear shows; instruction-clock runs last 64.
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                @(posedge i_clk);
                cs <= (s == 1) ? gst_pkg::CS_INST : gst_pkg::CS_SYS;
                presc <= p[1:0];
                wr_byte(1'b1, 8'h00);
                wr_byte(1'b0, 8'h00);
                run_for((s == 1) ? 64 : 67);
                note_exp(16'(((s == 1) ? 16 : 67) >> p), 4'h0);
            end
        end
        @(posedge i_clk);
        presc <= 2'h0;
        cs <= gst_pkg::CS_SYS;
        gate_en <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            @(posedge i_clk);
            gate_pol <= g[0];
            gate_pin <= g[1];
            wr_byte(1'b1, 8'h00);
            wr_byte(1'b0, 8'h00);
            run_for(20);
            note_exp((g[0] == g[1]) ? 16'h0014 : 16'h0000, 4'h0);
        end
        @(posedge i_clk);
        gate_en <= 1'b0;
        cs <= gst_pkg::CS_EXT;
        // Pin synchronised, pin asynchronous, then crystal; the idle source stays low.
        for (int m = 0; m < 3; m++) begin
            @(posedge i_clk);
            sync_dis <= (m != 0);
            osc_en <= (m == 2);
            tick(10);
            wr_byte(1'b1, 8'h00);
            wr_byte(1'b0, 8'h00);
            @(posedge i_clk);
            on <= 1'b1;
            tick(4);
            run_e <= (m != 2);
            run_x <= (m == 2);
            tick(60);
            run_e <= 1'b0;
            run_x <= 1'b0;
            tick(10);
            on <= 1'b0;
            note_exp(16'h0004, (m == 2) ? 4'h8 : 4'h0);
        end
        // No source selected, then the full-rate source asleep in synchronous mode.
        for (int t = 0; t < 2; t++) begin
            @(posedge i_clk);
            osc_en <= 1'b0;
            sync_dis <= 1'b0;
            cs <= (t == 0) ? 2'h3 : gst_pkg::CS_SYS;
            sleep <= (t == 1);
            wr_byte(1'b1, 8'h00);
            wr_byte(1'b0, 8'h00);
            run_for(20);
            note_exp(16'h0000, 4'h0);
        end
        @(posedge i_clk);
        sync_dis <= 1'b1;
        cs <= gst_pkg::CS_EXT;
        sleep <= 1'b1;
        int_en <= 1'b1;
        wr_byte(1'b1, 8'hff);
        wr_byte(1'b0, 8'hfe);
        @(posedge i_clk);
        on <= 1'b1;
        tick(4);
        run_e <= 1'b1;
        tick(36);
        run_e <= 1'b0;
        tick(10);
        note_exp(16'h0000, 4'h7);
        @(posedge i_clk);
        on <= 1'b0;
        sleep <= 1'b0;
        tick(3);
        note_exp(16'h0000, 4'h3);
        @(posedge i_clk);
        ovf_clr <= 1'b1;
        @(posedge i_clk);
        ovf_clr <= 1'b0;
        tick(3);
        note_exp(16'h0000, 4'h0);
        for (int r = 0; r < 3; r++) begin
            @(posedge i_clk);
            osc_go <= (r == 0);
            scs <= (r == 1) ? gst_pkg::SCS_SOSC : 2'h0;
            osc_other <= (r == 2);
            tick(3);
            note_exp(16'h0000, 4'h8);
            @(posedge i_clk);
            osc_go <= 1'b0;
            scs <= 2'h0;
            osc_other <= 1'b0;
            tick(3);
            note_exp(16'h0000, 4'h0);
        end
        tick(2);
        print_verdict();
    end
endmodule

`default_nettype wire
